// file: slps_link_model.sv
// Far-side line activity: a request frame in, then the reply out
`timescale 1ns/1ps
module slps_link_model (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic go_i,
   output logic      rx_o,
   output logic      tx_o
);
   logic [3:0] sh_q;
   // Reply leaves only after a turnaround, as a real master sees it
   always_ff @(posedge clk_i) begin
      if (reset_i) sh_q <= 4'h0;
      else sh_q <= {sh_q[2:0], go_i};
   end
   assign rx_o = sh_q[0];
   assign tx_o = sh_q[3];
endmodule // slps_link_model

// file: slps_pkg.sv
// Package for the serial link parameter select block: offsets, fields, resets, timing
package slps_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_UART_MODE  = 8'h00;  // stored serial mode (working copy)
   localparam logic [7:0] OFF_NODE_ADDR  = 8'h04;  // stored node address (working copy)
   localparam logic [7:0] OFF_COMMAND    = 8'h08;  // write: save / restart strobes
   localparam logic [7:0] OFF_ACTIVE     = 8'h0C;  // read: parameters in force
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;  // read: sticky events
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;  // write one to clear
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] OFF_LINK_CTRL  = 8'h1C;  // bit0: comm timeout flag from firmware

   // Mode field positions
   localparam int MODE_BAUD_BIT   = 0;  // 1 = 9600 bps, 0 = 19200 bps
   localparam int MODE_PARITY_BIT = 1;  // 1 = even parity, 0 = none

   // Command bits
   localparam int CMD_SAVE_BIT    = 0;
   localparam int CMD_RESTART_BIT = 1;

   // Interrupt event bits
   localparam int IRQ_SAVED_BIT   = 0;
   localparam int IRQ_REJECT_BIT  = 1;
   localparam int IRQ_TIMEOUT_BIT = 2;
   localparam int IRQ_WIDTH       = 3;

   // Factory defaults
   localparam logic [7:0] NODE_ADDR_DEFAULT = 8'h0F;
   localparam logic [7:0] NODE_ADDR_MIN     = 8'h01;
   localparam logic [7:0] NODE_ADDR_MAX     = 8'hFE;
   localparam logic [1:0] MODE_DEFAULT      = 2'h0;  // 19200, no parity, 8 data bits

   localparam logic [3:0] DATA_BITS         = 4'h8;

   // Blink timing
   localparam int CLK_HZ         = 100_000_000;
   localparam int PERIOD_MS      = 2000;
   localparam int SHORT_BLINK_MS = 100;
   localparam int PERIOD_CYC     = CLK_HZ / 1000 * PERIOD_MS;
   localparam int SHORT_CYC      = CLK_HZ / 1000 * SHORT_BLINK_MS;
   localparam int ACT_MS         = 20;
   localparam int ACT_CYC        = CLK_HZ / 1000 * ACT_MS;

   typedef struct packed {
      logic       baud_9600;
      logic       parity_even;
      logic [7:0] node_addr;
   } slps_cfg_t;

   typedef enum logic [1:0] {
      SLPS_LOAD = 2'b00,
      SLPS_RUN  = 2'b01
   } slps_state_t;

endpackage : slps_pkg

// file: slps_top.sv
// Serial link parameter selection, stored settings, status indication and APB registers
// Notes on behaviour
// - Active switch bank overrides stored settings
// - Stored settings used only when address switches zero
// - All switches off means stored settings
// - Defaults: 19200, 8 bits, no parity, 15
// - No-switch variants run 19200, no parity
// - Switch address weights 1, 2, 4, 8
// - Rate switch on 9600, off 19200
// - Parity switch off even, on none
// - Written address accepted only 1 to 254
// - New settings need save then restart
// - Save stores whole current configuration
// - Healthy link: short blink every 2 s
// - Timeout: 2 s lit, 2 s dark
// - TX and RX indicators blink on activity
// - Input indicator lit while input high
`timescale 1ns/1ps
module slps_top
   import slps_pkg::*;
#(
   parameter int  NUM_DI          = 8,
   parameter int  PERIOD_CYCLES   = slps_pkg::PERIOD_CYC,
   parameter int  SHORT_CYCLES    = slps_pkg::SHORT_CYC,
   parameter int  ACT_CYCLES      = slps_pkg::ACT_CYC,
   parameter bit  HAS_MODE_SW     = 1'b1
) (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   // APB slave
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [7:0]              paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output logic      [31:0]             prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   // Switch bank and line activity
   input  wire logic [3:0]              sw_addr_i,
   input  wire logic                    sw_rate_i,
   input  wire logic                    sw_parity_i,
   input  wire logic                    tx_active_i,
   input  wire logic                    rx_active_i,
   input  wire logic [NUM_DI-1:0]       di_i,
   // Configuration in force and indicators
   output slps_pkg::slps_cfg_t          active_cfg_o,
   output logic                         cfg_from_sw_o,
   output logic                         run_led_o,
   output logic                         tx_led_o,
   output logic                         rx_led_o,
   output logic      [NUM_DI-1:0]       di_led_o,
   output logic                         irq_o
);
   import slps_pkg::*;

   typedef struct packed {
      slps_state_t          st;
      slps_cfg_t            work;     // register copy written by software
      slps_cfg_t            saved;    // stored copy written by save, survives restart
      slps_cfg_t            active;
      logic                 from_sw;
      logic                 timeout;
      logic [31:0]          blink_cnt;
      logic [31:0]          tx_cnt;
      logic [31:0]          rx_cnt;
      logic [NUM_DI-1:0]    di_led;
      logic [IRQ_WIDTH-1:0] irq_sts;
      logic [IRQ_WIDTH-1:0] irq_en;
      logic [31:0]          rdata;
   } slps_state_all_t;

   slps_state_all_t s_q;
   slps_state_all_t s_d;

   logic       acc;
   logic       wr;
   logic       mapped;
   logic [IRQ_WIDTH-1:0] ev;
   logic [1:0] cmd_hit;

   assign acc      = psel_i & penable_i;
   assign wr       = acc & pwrite_i;
   assign mapped   = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFF_LINK_CTRL);

   always_comb begin
      s_d     = s_q;
      ev      = '0;
      cmd_hit = 2'h0;

      // Configuration loading happens only here, once per restart
      unique case (s_q.st)
         SLPS_LOAD: begin
            s_d.work = s_q.saved;
            if (sw_addr_i != 4'h0) begin
               s_d.active.node_addr = {4'h0, sw_addr_i};
               s_d.active.baud_9600   = HAS_MODE_SW ? sw_rate_i : 1'b0;
               s_d.active.parity_even = HAS_MODE_SW ? ~sw_parity_i : 1'b0;
               s_d.from_sw = 1'b0;
            end else begin
               s_d.active  = s_q.saved;
               if (!HAS_MODE_SW) begin
                  s_d.active.baud_9600   = 1'b0;
                  s_d.active.parity_even = 1'b0;
               end
               s_d.from_sw = 1'b1;
            end
            s_d.st = SLPS_RUN;
         end
         SLPS_RUN: begin
            s_d.st = SLPS_RUN;
         end
      endcase

      // Register writes
      if (wr && mapped) begin
         unique case (paddr_i)
            OFF_UART_MODE: begin
               s_d.work.baud_9600   = pwdata_i[MODE_BAUD_BIT];
               s_d.work.parity_even = pwdata_i[MODE_PARITY_BIT];
            end
            OFF_NODE_ADDR: begin
               if (pwdata_i >= 32'(NODE_ADDR_MIN) && pwdata_i <= 32'(NODE_ADDR_MAX)) begin
                  s_d.work.node_addr = pwdata_i[7:0];
               end else begin
                  ev[IRQ_REJECT_BIT] = 1'b1;
               end
            end
            OFF_COMMAND: begin
               if (pwdata_i[CMD_SAVE_BIT]) begin
                  s_d.saved = s_q.work;
                  ev[IRQ_SAVED_BIT] = 1'b1;
                  cmd_hit[0] = 1'b1;
               end
               if (pwdata_i[CMD_RESTART_BIT]) begin
                  s_d.st = SLPS_LOAD;
                  cmd_hit[1] = 1'b1;
               end
            end
            OFF_IRQ_CLEAR:  s_d.irq_sts = s_q.irq_sts & ~pwdata_i[IRQ_WIDTH-1:0];
            OFF_IRQ_ENABLE: s_d.irq_en  = pwdata_i[IRQ_WIDTH-1:0];
            OFF_LINK_CTRL: begin
               if (pwdata_i[0] && !s_q.timeout) begin
                  ev[IRQ_TIMEOUT_BIT] = 1'b1;
               end
               s_d.timeout = pwdata_i[0];
            end
            default: ;
         endcase
      end
      // A save in the same write as the restart reloads the fresh copy
      if (cmd_hit[0] && cmd_hit[1]) begin
         s_d.saved = s_q.work;
      end
      // Set wins over clear
      s_d.irq_sts = s_d.irq_sts | ev;

      // Read data, registered for the access cycle
      s_d.rdata = 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
         unique case (paddr_i)
            OFF_UART_MODE:  s_d.rdata = {30'h0, s_q.work.parity_even, s_q.work.baud_9600};
            OFF_NODE_ADDR:  s_d.rdata = {24'h0, s_q.work.node_addr};
            OFF_ACTIVE:     s_d.rdata = {17'h0, s_q.from_sw, DATA_BITS,
                                         s_q.active.parity_even, s_q.active.baud_9600,
                                         s_q.active.node_addr};
            OFF_IRQ_STATUS: s_d.rdata = {29'h0, s_q.irq_sts};
            OFF_IRQ_ENABLE: s_d.rdata = {29'h0, s_q.irq_en};
            OFF_LINK_CTRL:  s_d.rdata = {31'h0, s_q.timeout};
            default:        s_d.rdata = 32'h0000_0000;
         endcase
      end

      // Run indicator period counter
      if (s_q.blink_cnt >= 32'(2 * PERIOD_CYCLES - 1)) begin
         s_d.blink_cnt = 32'h0000_0000;
      end else begin
         s_d.blink_cnt = s_q.blink_cnt + 32'h0000_0001;
      end

      // Activity stretch so short frames stay visible
      s_d.tx_cnt = tx_active_i ? 32'(ACT_CYCLES) :
                   (s_q.tx_cnt != 32'h0 ? s_q.tx_cnt - 32'h1 : 32'h0);
      s_d.rx_cnt = rx_active_i ? 32'(ACT_CYCLES) :
                   (s_q.rx_cnt != 32'h0 ? s_q.rx_cnt - 32'h1 : 32'h0);

      s_d.di_led = di_i;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s_q.st        <= SLPS_LOAD;
         s_q.work      <= '{baud_9600: 1'b0, parity_even: 1'b0, node_addr: NODE_ADDR_DEFAULT};
         s_q.saved     <= '{baud_9600: MODE_DEFAULT[MODE_BAUD_BIT],
                            parity_even: MODE_DEFAULT[MODE_PARITY_BIT],
                            node_addr: NODE_ADDR_DEFAULT};
         s_q.active    <= '{baud_9600: 1'b0, parity_even: 1'b0, node_addr: NODE_ADDR_DEFAULT};
         s_q.from_sw   <= 1'b1;
         s_q.timeout   <= 1'b0;
         s_q.blink_cnt <= 32'h0000_0000;
         s_q.tx_cnt    <= 32'h0000_0000;
         s_q.rx_cnt    <= 32'h0000_0000;
         s_q.di_led    <= '0;
         s_q.irq_sts   <= '0;
         s_q.irq_en    <= '0;
         s_q.rdata     <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o      = s_q.rdata;
   assign pready_o      = 1'b1;
   assign pslverr_o     = acc & ~mapped;
   assign active_cfg_o  = s_q.active;
   assign cfg_from_sw_o = s_q.from_sw;
   // Timeout: lit first half of a 4 s cycle; healthy: short pulse each 2 s
   assign run_led_o     = s_q.timeout ? (s_q.blink_cnt < 32'(PERIOD_CYCLES)) :
                          ((s_q.blink_cnt % 32'(PERIOD_CYCLES)) < 32'(SHORT_CYCLES));
   assign tx_led_o      = s_q.tx_cnt != 32'h0;
   assign rx_led_o      = s_q.rx_cnt != 32'h0;
   assign di_led_o      = s_q.di_led;
   assign irq_o         = |(s_q.irq_sts & s_q.irq_en);

endmodule // slps_top

// file: slps_top_sva.sv
// Checker for the serial link parameter select block
`timescale 1ns/1ps
module slps_top_sva
   import slps_pkg::*;
#(parameter int NUM_DI = 8) (
   input wire logic              clk_i,
   input wire logic              reset_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [7:0]        paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pslverr_o,
   input wire logic [3:0]        sw_addr_i,
   input wire logic              tx_active_i,
   input wire logic              rx_active_i,
   input wire logic [NUM_DI-1:0] di_i,
   input wire slps_cfg_t         active_cfg_o,
   input wire logic              cfg_from_sw_o,
   input wire logic              tx_led_o,
   input wire logic              rx_led_o,
   input wire logic [NUM_DI-1:0] di_led_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic acc, rs, bad;
   assign acc = psel_i && penable_i;
   assign rs = acc && pwrite_i && paddr_i == OFF_COMMAND && pwdata_i[CMD_RESTART_BIT];
   assign bad = paddr_i > OFF_LINK_CTRL || paddr_i[1:0] != 2'h0;
   a_err_unmapped: assert property (acc && bad |-> pslverr_o && prdata_o == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && !bad |-> !pslverr_o)
      else $error("mapped access refused");
   // Settings may move only as the result of a restart command or a reset, never mid-run
   a_cfg_hold: assert property ($changed(active_cfg_o) |->
      $past(rs, 1) || $past(rs, 2) || $past(rs, 3) || $past(reset_i, 1) || $past(reset_i, 2))
      else $error("active settings changed without restart");
   a_sw_select: assert property (rs && sw_addr_i != 4'h0 |-> ##[1:3]
      (!cfg_from_sw_o && active_cfg_o.node_addr == {4'h0, sw_addr_i}))
      else $error("switch bank not taken on restart");
   a_sw_range: assert property (!cfg_from_sw_o |->
      active_cfg_o.node_addr[7:4] == 4'h0 && active_cfg_o.node_addr != 8'h00)
      else $error("switch source with bad address");
   a_addr_range: assert property (active_cfg_o.node_addr != 8'h00
      && active_cfg_o.node_addr != 8'hFF)
      else $error("node address out of range");
   a_di_copy: assert property (!$past(reset_i) |-> di_led_o == $past(di_i))
      else $error("input indicator wrong");
   a_tx_blink: assert property ($rose(tx_active_i) |=> tx_led_o)
      else $error("transmit indicator silent");
   a_rx_blink: assert property ($rose(rx_active_i) |=> rx_led_o)
      else $error("receive indicator silent");
endmodule // slps_top_sva
bind slps_top slps_top_sva #(.NUM_DI(NUM_DI)) u_sva (.clk_i, .reset_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .sw_addr_i, .tx_active_i,
   .rx_active_i, .di_i, .active_cfg_o, .cfg_from_sw_o, .tx_led_o, .rx_led_o, .di_led_o);

// file: test_serial_link_param_select.sv
// Self-checking bench for the serial link parameter select block
`timescale 1ns/1ps
module test_serial_link_param_select;
   import slps_pkg::*;
   logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, di = 8'h00, di_led_o;
   logic [31:0] pwdata = 32'h0000_0000, prdata_o, rd;
   logic pready_o, pslverr_o, er, sw_rate = 0, sw_par = 0, go = 0;
   logic tx_act, rx_act, cfg_from_sw_o, run_led_o, tx_led_o, rx_led_o, irq_o;
   logic [3:0] sw_addr = 4'h0;
   slps_cfg_t active_cfg_o, cfg_nosw;
   int error_cnt = 0, n_checks = 0, cyc = 0, cnt;
   slps_top #(.PERIOD_CYCLES(100), .SHORT_CYCLES(10), .ACT_CYCLES(5)) u_dut (
      .clk_i, .reset_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o, .pready_o, .pslverr_o,
      .sw_addr_i(sw_addr), .sw_rate_i(sw_rate), .sw_parity_i(sw_par),
      .tx_active_i(tx_act), .rx_active_i(rx_act), .di_i(di), .active_cfg_o,
      .cfg_from_sw_o, .run_led_o, .tx_led_o, .rx_led_o, .di_led_o, .irq_o);
   slps_link_model u_link (.clk_i, .reset_i, .go_i(go), .rx_o(rx_act), .tx_o(tx_act));
   // Variant without rate and parity switches shares every input with the main one
   slps_top #(.PERIOD_CYCLES(100), .SHORT_CYCLES(10), .ACT_CYCLES(5),
      .HAS_MODE_SW(1'b0)) u_dut_nosw (
      .clk_i, .reset_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(), .pready_o(), .pslverr_o(),
      .sw_addr_i(sw_addr), .sw_rate_i(sw_rate), .sw_parity_i(sw_par),
      .tx_active_i(tx_act), .rx_active_i(rx_act), .di_i(di), .active_cfg_o(cfg_nosw),
      .cfg_from_sw_o(), .run_led_o(), .tx_led_o(), .rx_led_o(), .di_led_o(), .irq_o());
   initial forever #5 clk_i = ~clk_i;
   // Ceiling lies far above the roughly 620 cycles that the scenarios need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Outputs read right after an edge are the values the design showed at that edge
   task nxt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Called and left on an edge; the spare edge after release leaves one idle cycle with psel low between transfers
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      nxt(1);
      penable <= 1'b1;
      do nxt(1); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
      nxt(1);
   endtask
   task restart;
      apb(1, OFF_COMMAND, 32'h0000_0002);
      nxt(3);
   endtask
   task run_cnt(input int n);
      cnt = 0;
      repeat (n) begin
         nxt(1);
         cnt += int'(run_led_o);
      end
   endtask
   task t_defaults;
      chk(32'(active_cfg_o), 32'h0000_000F);
      chk(32'(cfg_nosw), 32'h0000_000F);
      chk(32'(cfg_from_sw_o), 32'h0000_0001);
      apb(0, OFF_ACTIVE, 32'h0000_0000);
      chk(rd, 32'h0000_600F);
      apb(0, 8'h20, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
   endtask
   task t_store;
      apb(1, OFF_NODE_ADDR, 32'h0000_0000);
      apb(1, OFF_NODE_ADDR, 32'h0000_00FF);
      apb(0, OFF_NODE_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_000F);
      apb(1, OFF_IRQ_ENABLE, 32'h0000_0002);
      nxt(1);
      chk(32'(irq_o), 32'h0000_0001);
      apb(1, OFF_IRQ_CLEAR, 32'h0000_0007);
      nxt(1);
      chk(32'(irq_o), 32'h0000_0000);
      apb(1, OFF_NODE_ADDR, 32'h0000_00FE);
      apb(1, OFF_UART_MODE, 32'h0000_0001);
      apb(1, OFF_COMMAND, 32'h0000_0001);
      nxt(2);
      chk(32'(active_cfg_o), 32'h0000_000F);
      apb(0, OFF_IRQ_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1, OFF_NODE_ADDR, 32'h0000_0005);
      restart;
      chk(32'(active_cfg_o), 32'h0000_02FE);
      apb(0, OFF_NODE_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_00FE);
   endtask
   task t_switch;
      sw_addr <= 4'h3;
      sw_rate <= 1;
      nxt(3);
      chk(32'(active_cfg_o), 32'h0000_02FE);
      restart;
      chk(32'(active_cfg_o), 32'h0000_0303);
      chk(32'(cfg_nosw), 32'h0000_0003);
      for (int i = 0; i < 4; i++) begin
         sw_addr <= 4'(1 << i);
         sw_rate <= 0;
         sw_par <= 1;
         restart;
         chk(32'(active_cfg_o), 32'(1 << i));
      end
      sw_addr <= 4'h0;
      restart;
      chk(32'(active_cfg_o), 32'h0000_02FE);
      chk(32'(cfg_nosw), 32'h0000_00FE);
      chk(32'(cfg_from_sw_o), 32'h0000_0001);
   endtask
   task t_leds;
      logic rx_s, tx_s;
      di <= 8'hA5;
      nxt(2);
      chk(32'(di_led_o), 32'h0000_00A5);
      go <= 1;
      nxt(1);
      go <= 0;
      rx_s = 0;
      tx_s = 0;
      // Request frame is in, the reply has not left yet
      nxt(3);
      chk(32'({rx_led_o, tx_led_o}), 32'h0000_0002);
      repeat (17) begin
         nxt(1);
         rx_s |= rx_led_o;
         tx_s |= tx_led_o;
      end
      chk(32'({rx_s, tx_s, rx_led_o, tx_led_o}), 32'h0000_000C);
   endtask
   task t_run;
      run_cnt(100);
      chk(32'(cnt), 32'h0000_000A);
      apb(1, OFF_LINK_CTRL, 32'h0000_0001);
      nxt(200);
      run_cnt(200);
      chk(32'(cnt), 32'h0000_0064);
      apb(0, OFF_IRQ_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0004, 32'h0000_0004);
   endtask
   initial begin
      nxt(5);
      reset_i <= 0;
      nxt(2);
      t_defaults;
      t_store;
      t_switch;
      t_leds;
      t_run;
      wrap_up;
   end
endmodule // test_serial_link_param_select
